//--- rtl/pfbm_pkg.sv
// Package with timing, command and carrier types for the flash bus host controller.
package pfbm_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS          = 4000;
  localparam int ADDRESS_ACCESS_TIME_NS = 70;
  localparam int CE_ACCESS_TIME_NS      = 70;
  localparam int WRITE_PULSE_NS         = 35;
  localparam int WRITE_HIGH_NS          = 30;
  localparam int OE_HIGH_HOLD_NS        = 10;
  localparam int MIN_RESET_PULSE_NS     = 500;
  localparam int RESET_RECOVERY_TIME_NS = 50;
  localparam int SLEEP_ENTRY_EXTRA_NS   = 30;

  // Least times round up to whole cycles.
  localparam int ACC_CYC   = (ADDRESS_ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CE_CYC    = (CE_ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WP_CYC    = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WH_CYC    = (WRITE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OEH_CYC   = (OE_HIGH_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RP_CYC    = (MIN_RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RH_CYC    = (RESET_RECOVERY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W     = 8;

  // ---------------------------------------------------------------------------
  // Command bus encodings
  // ---------------------------------------------------------------------------
  localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
  localparam logic [11:0] UNLOCK2_ADDR = 12'h2aa;
  localparam logic [7:0]  UNLOCK1_DATA = 8'haa;
  localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  PROG_DATA    = 8'ha0;
  localparam logic [7:0]  ERASE_DATA   = 8'h80;
  localparam logic [7:0]  CHIP_DATA    = 8'h10;
  localparam logic [7:0]  SECT_DATA    = 8'h30;
  localparam logic [7:0]  IDENT_DATA   = 8'h90;
  localparam logic [7:0]  BYPASS_DATA  = 8'h20;
  localparam logic [7:0]  EXIT1_DATA   = 8'h90;
  localparam logic [7:0]  EXIT2_DATA   = 8'h00;
  localparam logic [7:0]  RESET_DATA   = 8'hf0;
  localparam int          SECT_LSB     = 15;

  typedef enum logic [3:0] {
    PFBM_OP_READ     = 4'h0,
    PFBM_OP_WRITE    = 4'h1,
    PFBM_OP_PROGRAM  = 4'h2,
    PFBM_OP_FASTPROG = 4'h3,
    PFBM_OP_SECTOR   = 4'h4,
    PFBM_OP_CHIP     = 4'h5,
    PFBM_OP_IDENT    = 4'h6,
    PFBM_OP_STATUS   = 4'h7,
    PFBM_OP_BYPASS   = 4'h8,
    PFBM_OP_UNBYPASS = 4'h9,
    PFBM_OP_RESET    = 4'ha,
    PFBM_OP_SECT_ADD = 4'hb
  } pfbm_op_e;

  // Request from the user side.
  typedef struct packed {
    pfbm_op_e    op;
    logic [21:0] addr;
    logic [15:0] data;
  } pfbm_req_s;

  // Pins toward the flash.
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        reset_n;
    logic        byte_n;
    logic        accel_high_voltage;
    logic [20:0] addr;
    logic [15:0] dq_out;
    logic [15:0] dq_oe;
  } pfbm_pins_s;

endpackage

//--- rtl/pfbm_sync.sv
// Three-stage input synchroniser with second/third agreement filter.
`timescale 1ns/1ps
`default_nettype none

module pfbm_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Data
  input  wire logic d_in,
  output var  logic q_out
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_ff <= RESET_VAL;
      s2_ff <= RESET_VAL;
      s3_ff <= RESET_VAL;
    end
    else
    begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A change counts once the second and third stages agree.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      q_out <= RESET_VAL;
    else if (s2_ff == s3_ff)
      q_out <= s3_ff;
  end

endmodule

`default_nettype wire

//--- rtl/pfbm_host.sv
// Host controller that drives a parallel NOR flash through its bus pins.
`timescale 1ns/1ps
`default_nettype none

module pfbm_host (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // User request
  input  wire logic                 req_valid,
  input  wire pfbm_pkg::pfbm_req_s  req,
  input  wire logic                 byte_mode,
  input  wire logic                 hw_reset_req,
  output var  logic                 req_ready,
  output var  logic                 rsp_valid,
  output var  logic [15:0]          rsp_data,
  output var  logic                 fast_mode,
  // Flash pins
  output var  pfbm_pkg::pfbm_pins_s pins,
  input  wire logic [15:0]          dq_in,
  input  wire logic                 ready_busy_out
);

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_SETUP = 4'b0001,
    S_WLOW  = 4'b0011,
    S_WHIGH = 4'b0010,
    S_RWAIT = 4'b0110,
    S_RDONE = 4'b0111,
    S_RSTLO = 4'b0101,
    S_RSTHI = 4'b0100,
    S_RSTRC = 4'b1100
  } pfbm_state_e;

  pfbm_state_e               state_ff;
  logic [pfbm_pkg::CNT_W-1:0] cnt_ff;
  logic [2:0]                 step_ff;
  logic [2:0]                 nsteps_ff;
  logic                       is_read_ff;
  logic                       bypass_ff;
  logic                       rb_sync;
  pfbm_pkg::pfbm_req_s        cur_ff;
  logic [11:0]                wa;
  logic [7:0]                 wd;
  logic [7:0]                 wdh;
  logic                       use_addr;
  logic [20:0]                last_addr_ff;

  pfbm_sync #(.RESET_VAL(1'b1)) u_rb (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d_in    (ready_busy_out),
    .q_out   (rb_sync)
  );

  // ---------------------------------------------------------------------------
  // Cycle contents of each command sequence
  // ---------------------------------------------------------------------------
  always_comb
  begin
    wa = pfbm_pkg::UNLOCK1_ADDR;
    wd = pfbm_pkg::UNLOCK1_DATA;
    wdh = 8'h00;
    use_addr = 1'b0;
    case (cur_ff.op)
      pfbm_pkg::PFBM_OP_FASTPROG:
      begin
        wd = pfbm_pkg::PROG_DATA;
        if (step_ff == 3'h1)
        begin
          wa = cur_ff.addr[11:0];
          wd = cur_ff.data[7:0];
          wdh = cur_ff.data[15:8];
          use_addr = 1'b1;
        end
      end
      pfbm_pkg::PFBM_OP_UNBYPASS:
        wd = (step_ff == 3'h0) ? pfbm_pkg::EXIT1_DATA : pfbm_pkg::EXIT2_DATA;
      pfbm_pkg::PFBM_OP_RESET, pfbm_pkg::PFBM_OP_WRITE:
      begin
        wa = cur_ff.addr[11:0];
        wd = (cur_ff.op == pfbm_pkg::PFBM_OP_RESET) ? pfbm_pkg::RESET_DATA : cur_ff.data[7:0];
      end
      pfbm_pkg::PFBM_OP_SECT_ADD:
      begin
        wa = cur_ff.addr[11:0];
        wd = pfbm_pkg::SECT_DATA;
        use_addr = 1'b1;
      end
      default:
      begin
        case (step_ff)
          3'h1, 3'h4:
          begin
            wa = pfbm_pkg::UNLOCK2_ADDR;
            wd = pfbm_pkg::UNLOCK2_DATA;
          end
          3'h2:
          begin
            case (cur_ff.op)
              pfbm_pkg::PFBM_OP_PROGRAM: wd = pfbm_pkg::PROG_DATA;
              pfbm_pkg::PFBM_OP_IDENT:   wd = pfbm_pkg::IDENT_DATA;
              pfbm_pkg::PFBM_OP_BYPASS:  wd = pfbm_pkg::BYPASS_DATA;
              default:                   wd = pfbm_pkg::ERASE_DATA;
            endcase
          end
          3'h3:
          begin
            if (cur_ff.op == pfbm_pkg::PFBM_OP_PROGRAM)
            begin
              wa = cur_ff.addr[11:0];
              wd = cur_ff.data[7:0];
              wdh = cur_ff.data[15:8];
              use_addr = 1'b1;
            end
          end
          3'h5:
          begin
            if (cur_ff.op == pfbm_pkg::PFBM_OP_SECTOR)
            begin
              use_addr = 1'b1;
              wd = pfbm_pkg::SECT_DATA;
            end
            else
              wd = pfbm_pkg::CHIP_DATA;
          end
          default:
          begin
            wa = pfbm_pkg::UNLOCK1_ADDR;
          end
        endcase
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Bus sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff   <= S_RSTLO;
      cnt_ff     <= '0;
      step_ff    <= '0;
      nsteps_ff  <= '0;
      is_read_ff <= 1'b0;
      cur_ff     <= '0;
    end
    else
    begin
      case (state_ff)
        S_IDLE:
        begin
          if (hw_reset_req)
          begin
            state_ff <= S_RSTLO;
            cnt_ff   <= '0;
          end
          else if (req_valid)
          begin
            cur_ff     <= req;
            step_ff    <= '0;
            is_read_ff <= (req.op == pfbm_pkg::PFBM_OP_READ) || (req.op == pfbm_pkg::PFBM_OP_STATUS);
            case (req.op)
              pfbm_pkg::PFBM_OP_PROGRAM, pfbm_pkg::PFBM_OP_IDENT,
              pfbm_pkg::PFBM_OP_BYPASS:                               nsteps_ff <= 3'h3;
              pfbm_pkg::PFBM_OP_SECTOR, pfbm_pkg::PFBM_OP_CHIP:       nsteps_ff <= 3'h5;
              pfbm_pkg::PFBM_OP_FASTPROG, pfbm_pkg::PFBM_OP_UNBYPASS: nsteps_ff <= 3'h1;
              default:                                                nsteps_ff <= 3'h0;
            endcase
            cnt_ff   <= '0;
            state_ff <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          cnt_ff   <= '0;
          state_ff <= is_read_ff ? S_RWAIT : S_WLOW;
        end
        S_WLOW:
        begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == pfbm_pkg::CNT_W'(pfbm_pkg::WP_CYC - 1))
          begin
            cnt_ff   <= '0;
            state_ff <= S_WHIGH;
          end
        end
        S_WHIGH:
        begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == pfbm_pkg::CNT_W'(pfbm_pkg::WH_CYC - 1))
          begin
            cnt_ff <= '0;
            if (step_ff == nsteps_ff)
              state_ff <= S_RDONE;
            else
            begin
              step_ff  <= step_ff + 3'h1;
              state_ff <= S_WLOW;
            end
          end
        end
        S_RWAIT:
        begin
          // Access time covers both chip-select and address access.
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == pfbm_pkg::CNT_W'(pfbm_pkg::CE_CYC + 1))
          begin
            cnt_ff   <= '0;
            state_ff <= S_RDONE;
          end
        end
        S_RDONE:
        begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == pfbm_pkg::CNT_W'(pfbm_pkg::OEH_CYC - 1))
          begin
            cnt_ff   <= '0;
            state_ff <= S_IDLE;
          end
        end
        S_RSTLO:
        begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == pfbm_pkg::CNT_W'(pfbm_pkg::RP_CYC - 1))
          begin
            cnt_ff   <= '0;
            state_ff <= S_RSTHI;
          end
        end
        S_RSTHI:
        begin
          if (rb_sync)
            state_ff <= S_RSTRC;
        end
        S_RSTRC:
        begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff == pfbm_pkg::CNT_W'(pfbm_pkg::RH_CYC - 1))
          begin
            cnt_ff   <= '0;
            state_ff <= S_IDLE;
          end
        end
        default:
          state_ff <= S_RSTLO;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Fast mode tracking and acceleration pin
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      bypass_ff <= 1'b0;
    else if (state_ff == S_RSTLO)
      bypass_ff <= 1'b0;
    else if (state_ff == S_RDONE && cnt_ff == '0 && cur_ff.op == pfbm_pkg::PFBM_OP_BYPASS)
      bypass_ff <= 1'b1;
    else if (state_ff == S_RDONE && cnt_ff == '0 && cur_ff.op == pfbm_pkg::PFBM_OP_UNBYPASS)
      bypass_ff <= 1'b0;
  end

  assign fast_mode = bypass_ff;

  // ---------------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pins         <= '0;
      pins.ce_n    <= 1'b1;
      pins.oe_n    <= 1'b1;
      pins.we_n    <= 1'b1;
      pins.byte_n  <= 1'b1;
      last_addr_ff <= '0;
    end
    else
    begin
      pins.reset_n <= !(state_ff == S_RSTLO);
      pins.byte_n  <= !byte_mode;
      // Acceleration voltage only while an accelerated program runs.
      pins.accel_high_voltage <= (cur_ff.op == pfbm_pkg::PFBM_OP_FASTPROG) && !bypass_ff &&
                                 (state_ff == S_SETUP || state_ff == S_WLOW || state_ff == S_WHIGH);
      // Deselect in idle; device finishes any running operation itself.
      pins.ce_n <= !(state_ff == S_SETUP || state_ff == S_WLOW || state_ff == S_WHIGH ||
                     state_ff == S_RWAIT);
      pins.we_n <= !(state_ff == S_WLOW);
      pins.oe_n <= !(state_ff == S_RWAIT);
      if (state_ff == S_WLOW || state_ff == S_WHIGH)
      begin
        // Data and sector cycles carry the full word address of the request.
        pins.addr   <= use_addr ? cur_ff.addr[21:1] : {9'h000, wa};
        pins.dq_out <= byte_mode ? {cur_ff.addr[0], 7'h00, wd} : {wdh, wd};
        pins.dq_oe  <= byte_mode ? 16'h80ff : 16'hffff;
      end
      else
      begin
        pins.dq_oe <= '0;
        if (state_ff == S_SETUP)
        begin
          pins.addr    <= cur_ff.addr[21:1];
          last_addr_ff <= cur_ff.addr[21:1];
          // Lowest byte address travels on the top data pin in byte mode.
          pins.dq_out[15] <= cur_ff.addr[0];
          pins.dq_oe[15]  <= byte_mode;
        end
        else if (state_ff == S_RWAIT)
        begin
          pins.dq_out[15] <= cur_ff.addr[0];
          pins.dq_oe[15]  <= byte_mode;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // User side answer
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end
    else
    begin
      req_ready <= (state_ff == S_IDLE) && !req_valid && !hw_reset_req;
      rsp_valid <= (state_ff == S_RWAIT) && (cnt_ff == pfbm_pkg::CNT_W'(pfbm_pkg::CE_CYC + 1));
      if ((state_ff == S_RWAIT) && (cnt_ff == pfbm_pkg::CNT_W'(pfbm_pkg::CE_CYC + 1)))
        rsp_data <= (byte_mode || cur_ff.op == pfbm_pkg::PFBM_OP_STATUS) ?
                    {8'h00, dq_in[7:0]} : dq_in;
    end
  end

  a_rst_pulse_len: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(pins.reset_n) |-> $past(!pins.reset_n, pfbm_pkg::RP_CYC))
    else $error("reset pulse too short");
  a_write_oe_high: assert property (@(posedge ref_clk) disable iff (rst)
    !pins.we_n |-> pins.oe_n && !pins.ce_n)
    else $error("write with output enable low");
  a_read_we_high: assert property (@(posedge ref_clk) disable iff (rst)
    !pins.oe_n |-> pins.we_n && !pins.ce_n && pins.dq_oe[14:0] == '0)
    else $error("read while driving data or writing");
  a_ready_after_rst: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == S_RSTHI && !rb_sync) |=> state_ff == S_RSTHI)
    else $error("left reset while busy");
  a_recovery_wait: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(pins.reset_n) |-> ##1 pins.oe_n [*8])
    else $error("read too soon after reset");
  a_read_access: assert property (@(posedge ref_clk) disable iff (rst)
    rsp_valid |-> $past(!pins.oe_n, 2) && $past(!pins.oe_n, pfbm_pkg::CE_CYC))
    else $error("data sampled before access time");
  a_accel_only_prog: assert property (@(posedge ref_clk) disable iff (rst)
    pins.accel_high_voltage |-> cur_ff.op == pfbm_pkg::PFBM_OP_FASTPROG)
    else $error("acceleration voltage outside program");
  a_byte_tristate: assert property (@(posedge ref_clk) disable iff (rst)
    !pins.byte_n |-> pins.dq_oe[14:8] == '0)
    else $error("middle data pins driven in byte mode");

  c_read: cover property (@(posedge ref_clk) rsp_valid);
  c_fast: cover property (@(posedge ref_clk) $rose(bypass_ff));
  c_reset: cover property (@(posedge ref_clk) $rose(pins.reset_n));
  c_write: cover property (@(posedge ref_clk) $fell(pins.we_n));

endmodule

`default_nettype wire

//--- verif/pfbm_flash_model.sv
// Behavioural model of the parallel flash device seen through its bus pins.
`timescale 1ns/1ps
`default_nettype none

module pfbm_flash_model #(
  parameter int         PROG_CYC    = 100,
  parameter int         ERASE_CYC   = 400,
  parameter int         RST_EMB_CYC = 60,
  // Arbitrary identification value.
  parameter logic [7:0] ID_CODE     = 8'h5e
) (
  // Clock
  input  wire logic                 ref_clk,
  // Pins from the host
  input  wire pfbm_pkg::pfbm_pins_s pins,
  // Pins toward the host
  output var  logic [15:0]          dq_in,
  output var  logic                 ready_busy_out
);
  logic [7:0]  mem [logic [21:0]];
  logic [2:0]  st = '0;
  logic        ident = 1'b0;
  logic        byp = 1'b0;
  logic        erasing = 1'b0;
  logic        we_q = 1'b1;
  logic        accel_q = 1'b0;
  logic        pbit = 1'b0;
  logic [63:0] sect_set = '0;
  logic [20:0] addr_q = '0;
  logic [15:0] last = '0;
  int          busy_cnt = 0;
  int          acc_cnt = 0;

  function automatic logic [7:0] rd(input logic [21:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction

  initial
  begin
    mem[22'h000100] = 8'h34;
    mem[22'h000101] = 8'h12;
    mem[22'h020010] = 8'hcd;
    mem[22'h020011] = 8'hab;
    dq_in = '0;
    ready_busy_out = 1'b1;
  end

  always @(posedge ref_clk)
  begin : proc
    logic [21:0] ba;
    logic [7:0]  d;
    logic        wr;
    logic [15:0] o;
    logic [21:0] kq [$];
    ba = pins.byte_n ? {pins.addr, 1'b0} : {pins.addr, pins.dq_out[15]};
    d = pins.dq_out[7:0];
    wr = we_q === 1'b0 && pins.we_n === 1'b1 && pins.ce_n === 1'b0 && pins.oe_n === 1'b1;
    we_q = pins.we_n;
    if (accel_q && !pins.accel_high_voltage) byp = 1'b0;
    accel_q = pins.accel_high_voltage;
    if (erasing && busy_cnt == 1)
    begin
      foreach (mem[k]) if (sect_set[k[21:16]]) kq.push_back(k);
      foreach (kq[i]) mem.delete(kq[i]);
      erasing = 1'b0;
    end
    if (busy_cnt > 0) busy_cnt--;
    if (pins.reset_n !== 1'b1)
    begin
      st = '0;
      ident = 1'b0;
      byp = 1'b0;
      erasing = 1'b0;
      if (busy_cnt > RST_EMB_CYC) busy_cnt = RST_EMB_CYC;
    end
    else if (wr && d == 8'hf0 && st != 3'd3)
    begin
      st = '0;
      ident = 1'b0;
    end
    else if (wr)
    begin
      case (st)
        3'd0:
        begin
          if (byp || pins.accel_high_voltage)
          begin
            if (d == 8'ha0) st = 3'd3;
            else if (d == 8'h90) st = 3'd7;
          end
          else if (d == 8'haa) st = 3'd1;
          else if (erasing && d == 8'h30)
          begin
            sect_set[ba[21:16]] = 1'b1;
            busy_cnt = ERASE_CYC;
          end
        end
        3'd1: st = (d == 8'h55) ? 3'd2 : 3'd0;
        3'd2:
        begin
          st = (d == 8'ha0) ? 3'd3 : (d == 8'h80) ? 3'd4 : 3'd0;
          if (d == 8'h90) ident = 1'b1;
          if (d == 8'h20) byp = 1'b1;
        end
        3'd3:
        begin
          mem[ba] = rd(ba) & d;
          if (pins.byte_n) mem[{ba[21:1], 1'b1}] = rd({ba[21:1], 1'b1}) & pins.dq_out[15:8];
          pbit = d[7];
          busy_cnt = PROG_CYC;
          st = '0;
        end
        3'd4: st = (d == 8'haa) ? 3'd5 : 3'd0;
        3'd5: st = (d == 8'h55) ? 3'd6 : 3'd0;
        3'd6:
        begin
          st = '0;
          if (d == 8'h10 || d == 8'h30)
          begin
            sect_set = (d == 8'h10) ? '1 : '0;
            sect_set[ba[21:16]] = 1'b1;
            erasing = 1'b1;
            pbit = 1'b1;
            busy_cnt = ERASE_CYC;
          end
        end
        default:
        begin
          st = '0;
          if (d == 8'h00) byp = 1'b0;
        end
      endcase
    end
    if (pins.ce_n === 1'b0 && pins.oe_n === 1'b0 && pins.reset_n === 1'b1 && pins.addr == addr_q)
      acc_cnt++;
    else
      acc_cnt = 0;
    addr_q = pins.addr;
    if (acc_cnt >= pfbm_pkg::CE_CYC - 2)
    begin
      if (busy_cnt > 0) o = {~last[15:8], ~pbit, 7'h00};
      else if (ident) o = {~last[15:8], ID_CODE};
      else if (!pins.byte_n) o = {~last[15:8], rd(ba)};
      else o = {rd({ba[21:1], 1'b1}), rd(ba)};
      last = o;
    end
    else
      last = ~last;
    dq_in <= last;
    ready_busy_out <= (busy_cnt == 0);
  end
endmodule

`default_nettype wire

//--- verif/pfbm_host_test.sv
// Self-checking testbench for the flash bus host controller.
`timescale 1ns/1ps
`default_nettype none

module pfbm_host_test;
  // Arbitrary identification value.
  localparam logic [7:0] ID_CODE = 8'h5e;
  logic                 ref_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 req_valid = 1'b0;
  logic                 byte_mode = 1'b0;
  logic                 hw_reset_req = 1'b0;
  pfbm_pkg::pfbm_req_s  req = '0;
  logic                 req_ready;
  logic                 rsp_valid;
  logic                 fast_mode;
  logic                 ready_busy_out;
  logic [15:0]          rsp_data;
  logic [15:0]          dq_in;
  pfbm_pkg::pfbm_pins_s pins;
  int                   mismatches = 0;
  int                   checked = 0;
  integer               seed = 32'h2bd7;
  logic [15:0]          exp_q [$];
  logic [15:0]          msk_q [$];
  logic [21:0]          ra;
  logic [15:0]          rv;

  pfbm_host i_pfbm_host (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .byte_mode(byte_mode), .hw_reset_req(hw_reset_req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .fast_mode(fast_mode), .pins(pins),
    .dq_in(dq_in), .ready_busy_out(ready_busy_out));

  pfbm_flash_model #(.ID_CODE(ID_CODE)) i_pfbm_flash_model (.ref_clk(ref_clk), .pins(pins),
    .dq_in(dq_in), .ready_busy_out(ready_busy_out));

  initial forever #2 ref_clk = ~ref_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Bounded waits
  // ---------------------------------------------------------------------------
  task automatic wait_sig(input bit dev);
    int n;
    n = 0;
    while ((dev ? ready_busy_out : req_ready) !== 1'b1 && n < 5000)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 5000)
    begin
      check(16'h0, 16'h1);
      end_of_test();
    end
  endtask

  // ---------------------------------------------------------------------------
  // Request driving
  // ---------------------------------------------------------------------------
  task automatic op(input pfbm_pkg::pfbm_op_e o, input logic [21:0] a, input logic [15:0] d);
    wait_sig(1'b0);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{op: o, addr: a, data: d};
    @(posedge ref_clk);
    req_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    wait_sig(1'b0);
  endtask

  task automatic rd(input pfbm_pkg::pfbm_op_e o, input logic [21:0] a, input logic [15:0] e,
                    input logic [15:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    op(o, a, 16'h0000);
  endtask

  task automatic hwr;
    wait_sig(1'b0);
    @(posedge ref_clk);
    hw_reset_req <= 1'b1;
    @(posedge ref_clk);
    hw_reset_req <= 1'b0;
    repeat (3) @(posedge ref_clk);
    wait_sig(1'b0);
    check(16'(ready_busy_out), 16'h1);
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  always @(posedge ref_clk)
  begin
    if (rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(rsp_data, ~rsp_data);
      else
        check(rsp_data & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    wait_sig(1'b0);
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000100, 16'h1234, 16'hffff);
    done("power_up_read");
    op(pfbm_pkg::PFBM_OP_PROGRAM, 22'h000200, 16'h5a3c);
    rd(pfbm_pkg::PFBM_OP_STATUS, 22'h000200, 16'h0080, 16'h00ff);
    wait_sig(1'b1);
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000200, 16'h5a3c, 16'hffff);
    done("program_status");
    @(posedge ref_clk);
    byte_mode <= 1'b1;
    op(pfbm_pkg::PFBM_OP_PROGRAM, 22'h000301, 16'h0077);
    wait_sig(1'b1);
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000301, 16'h0077, 16'h00ff);
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000300, 16'h00ff, 16'h00ff);
    @(posedge ref_clk);
    byte_mode <= 1'b0;
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000300, 16'h77ff, 16'hffff);
    done("byte_mode");
    for (int i = 0; i < 6; i++)
    begin
      ra = 22'h030000 + 22'(i * 64) + 22'($random(seed) & 62);
      rv = 16'($random(seed));
      op(pfbm_pkg::PFBM_OP_PROGRAM, ra, rv);
      wait_sig(1'b1);
      rd(pfbm_pkg::PFBM_OP_READ, ra, rv, 16'hffff);
    end
    done("random_program");
    op(pfbm_pkg::PFBM_OP_BYPASS, 22'h000000, 16'h0000);
    check(16'(fast_mode), 16'h1);
    op(pfbm_pkg::PFBM_OP_FASTPROG, 22'h000400, 16'hc3e1);
    wait_sig(1'b1);
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000400, 16'hc3e1, 16'hffff);
    op(pfbm_pkg::PFBM_OP_UNBYPASS, 22'h000000, 16'h0000);
    check(16'(fast_mode), 16'h0);
    done("unlock_bypass");
    op(pfbm_pkg::PFBM_OP_FASTPROG, 22'h000500, 16'h9876);
    wait_sig(1'b1);
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000500, 16'h9876, 16'hffff);
    op(pfbm_pkg::PFBM_OP_PROGRAM, 22'h000600, 16'h4321);
    wait_sig(1'b1);
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000600, 16'h4321, 16'hffff);
    done("accelerated");
    op(pfbm_pkg::PFBM_OP_IDENT, 22'h000000, 16'h0000);
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000000, {8'h00, ID_CODE}, 16'h00ff);
    op(pfbm_pkg::PFBM_OP_RESET, 22'h000000, 16'h0000);
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000100, 16'h1234, 16'hffff);
    op(pfbm_pkg::PFBM_OP_IDENT, 22'h000000, 16'h0000);
    hwr();
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000100, 16'h1234, 16'hffff);
    done("ident_and_reset");
    op(pfbm_pkg::PFBM_OP_SECTOR, 22'h030000, 16'h0000);
    op(pfbm_pkg::PFBM_OP_SECT_ADD, 22'h020000, 16'h0000);
    rd(pfbm_pkg::PFBM_OP_STATUS, 22'h030000, 16'h0000, 16'h0080);
    wait_sig(1'b1);
    rd(pfbm_pkg::PFBM_OP_READ, ra, 16'hffff, 16'hffff);
    rd(pfbm_pkg::PFBM_OP_READ, 22'h020010, 16'hffff, 16'hffff);
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000100, 16'h1234, 16'hffff);
    done("sector_erase");
    op(pfbm_pkg::PFBM_OP_SECTOR, 22'h000000, 16'h0000);
    hwr();
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000100, 16'h1234, 16'hffff);
    done("reset_during_erase");
    op(pfbm_pkg::PFBM_OP_CHIP, 22'h000000, 16'h0000);
    wait_sig(1'b1);
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000100, 16'hffff, 16'hffff);
    rd(pfbm_pkg::PFBM_OP_READ, 22'h000600, 16'hffff, 16'hffff);
    done("chip_erase");
    repeat (40) @(posedge ref_clk);
    check(16'(exp_q.size()), 16'h0);
    end_of_test();
  end
endmodule

`default_nettype wire
